// [design/spsp_status.sv]
// Status, prescaler and interrupt logic of the synchronous serial port
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "spsp_consts.svh"

module spsp_status
    import spsp_pkg::*;
#(
    parameter int DEPTH      = 8,                  // FIFO depth
    parameter int DATA_W     = 16,                 // FIFO entry width
    parameter int TIMEOUT_B  = `SPSP_TIMEOUT_BITS  // Time-out in bit periods
) (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // AXI4-Lite slave
    input  wire spsp_axi_req_t axi_req,
    output spsp_axi_rsp_t      axi_rsp,
    // FIFO state from the data path
    input  wire spsp_fifo_t    fifo,
    input  wire logic          port_enable,
    // Outputs to the data path
    output logic               bit_tick,
    output logic [3:0]         irq_masked,
    output logic [DATA_W-1:0]  width_mask
);

    // ****************************************
    // Decode helpers
    // ****************************************
    // Word offset match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    localparam logic [4:0] DEPTH_C = 5'(DEPTH);
    localparam logic [4:0] HALF_C  = 5'(DEPTH / 2);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]  prescale;   // Divisor field
        logic [3:0]  irq_en;     // Interrupt enables
        logic        rt_raw;     // Sticky time-out
        logic        ror_raw;    // Sticky overrun
        logic [15:0] to_cnt;     // Bit periods since activity
        logic        awv;        // Write address held
        logic [11:0] awa;
        logic        wv;         // Write data held
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } spsp_state_t;

    spsp_state_t st_reg;   // Registered state
    spsp_state_t st_next;  // Next state

    // Live conditions
    logic [4:0]  status_w;   // Status register contents
    logic [3:0]  raw_w;      // Raw interrupt status
    logic        do_write;   // Write commits this cycle
    logic [11:0] rd_addr;    // Read address

    // ****************************************
    // Status and raw conditions
    // ****************************************
    always_comb begin
        status_w = '0;
        status_w[`SPSP_ST_BUSY] = fifo.shifting || (fifo.tx_count != 5'd0);
        status_w[`SPSP_ST_RX_FULL]  = (fifo.rx_count == DEPTH_C);
        status_w[`SPSP_ST_RX_AVAIL] = (fifo.rx_count != 5'd0);
        status_w[`SPSP_ST_TX_ROOM]  = (fifo.tx_count != DEPTH_C);
        status_w[`SPSP_ST_TX_EMPTY] = (fifo.tx_count == 5'd0);
        raw_w = '0;
        raw_w[`SPSP_IRQ_TX]  = (fifo.tx_count <= HALF_C);
        // Level condition as printed: half full or less, gated by data present
        raw_w[`SPSP_IRQ_RX]  = (fifo.rx_count != 5'd0) && (fifo.rx_count <= HALF_C);
        raw_w[`SPSP_IRQ_RT]  = st_reg.rt_raw;
        raw_w[`SPSP_IRQ_ROR] = st_reg.ror_raw;
    end

    assign irq_masked = raw_w & st_reg.irq_en;
    assign width_mask = {DATA_W{1'b1}};
    assign do_write   = st_reg.awv && st_reg.wv && !st_reg.bvalid;
    assign rd_addr    = axi_req.araddr;

    // ****************************************
    // Prescaler
    // ****************************************
    spsp_prescale u_pre (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (port_enable),
        .divisor  (st_reg.prescale),
        .bit_tick (bit_tick)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Time-out counter restarts on activity or when empty
        if (fifo.rx_pop || fifo.rx_push || !status_w[`SPSP_ST_RX_AVAIL]) begin
            st_next.to_cnt = 16'h0000;
        end else if (bit_tick && st_reg.to_cnt != 16'(TIMEOUT_B)) begin
            st_next.to_cnt = st_reg.to_cnt + 16'h0001;
        end
        // Write channel capture, either order
        if (axi_req.awvalid && !st_reg.awv) begin
            st_next.awv = 1'b1;
            st_next.awa = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st_reg.wv) begin
            st_next.wv = 1'b1;
            st_next.wd = axi_req.wdata;
            st_next.ws = axi_req.wstrb;
        end
        // Clear applied first so a same-cycle event wins
        if (do_write) begin
            st_next.awv    = 1'b0;
            st_next.wv     = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = `SPSP_RESP_OKAY;
            if (hit(st_reg.awa, `SPSP_OFF_PRESCALE)) begin
                if (st_reg.ws[0]) begin
                    st_next.prescale = {st_reg.wd[7:1], 1'b0};
                end
            end else if (hit(st_reg.awa, `SPSP_OFF_IRQ_EN)) begin
                if (st_reg.ws[0]) begin
                    st_next.irq_en = st_reg.wd[3:0];
                end
            end else if (hit(st_reg.awa, `SPSP_OFF_CLEAR)) begin
                if (st_reg.ws[0] && st_reg.wd[`SPSP_IRQ_RT]) begin
                    st_next.rt_raw = 1'b0;
                end
                if (st_reg.ws[0] && st_reg.wd[`SPSP_IRQ_ROR]) begin
                    st_next.ror_raw = 1'b0;
                end
            end else if (hit(st_reg.awa, `SPSP_OFF_STATUS)
                      || hit(st_reg.awa, `SPSP_OFF_RAW)
                      || hit(st_reg.awa, `SPSP_OFF_MASKED)) begin
                // Read-only registers ignore writes
                st_next.bresp = `SPSP_RESP_OKAY;
            end else begin
                st_next.bresp = `SPSP_RESP_SLVERR;
            end
        end
        // Sticky events set after clears
        if (st_reg.to_cnt == 16'(TIMEOUT_B) - 16'h0001 && bit_tick
            && !fifo.rx_pop && !fifo.rx_push && status_w[`SPSP_ST_RX_AVAIL]) begin
            st_next.rt_raw = 1'b1;
        end
        if (fifo.rx_push && status_w[`SPSP_ST_RX_FULL]) begin
            st_next.ror_raw = 1'b1;
        end
        if (st_reg.bvalid && axi_req.bready) begin
            st_next.bvalid = 1'b0;
        end
        // Read channel
        if (st_reg.rvalid && axi_req.rready) begin
            st_next.rvalid = 1'b0;
        end
        if (axi_req.arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = `SPSP_RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            if (hit(rd_addr, `SPSP_OFF_STATUS)) begin
                st_next.rdata[4:0] = status_w;
            end else if (hit(rd_addr, `SPSP_OFF_PRESCALE)) begin
                st_next.rdata[7:0] = {st_reg.prescale[7:1], 1'b0};
            end else if (hit(rd_addr, `SPSP_OFF_IRQ_EN)) begin
                st_next.rdata[3:0] = st_reg.irq_en;
            end else if (hit(rd_addr, `SPSP_OFF_RAW)) begin
                st_next.rdata[3:0] = raw_w;
            end else if (hit(rd_addr, `SPSP_OFF_MASKED)) begin
                st_next.rdata[3:0] = irq_masked;
            end else if (!hit(rd_addr, `SPSP_OFF_CLEAR)) begin
                st_next.rresp = `SPSP_RESP_SLVERR;
            end
        end
    end

    // Register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg          <= '0;
            st_reg.prescale <= `SPSP_RST_PRESCALE;
            st_reg.irq_en   <= `SPSP_RST_IRQ_EN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Bus answers
    // ****************************************
    always_comb begin
        axi_rsp         = '0;
        axi_rsp.awready = !st_reg.awv;
        axi_rsp.wready  = !st_reg.wv;
        axi_rsp.bvalid  = st_reg.bvalid;
        axi_rsp.bresp   = st_reg.bresp;
        axi_rsp.arready = !st_reg.rvalid;
        axi_rsp.rvalid  = st_reg.rvalid;
        axi_rsp.rdata   = st_reg.rdata;
        axi_rsp.rresp   = st_reg.rresp;
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Busy bit as read back follows frame and transmit state
    property p_busy;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.rvalid) && hit($past(rd_addr), `SPSP_OFF_STATUS)
            |-> st_reg.rdata[`SPSP_ST_BUSY] == ($past(fifo.shifting)
                                               || $past(fifo.tx_count) != 5'd0);
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");

    // A full receive FIFO is also not empty
    property p_full;
        @(posedge aclk) disable iff (!aresetn)
        (fifo.rx_count == DEPTH_C)
            |-> status_w[`SPSP_ST_RX_FULL] && status_w[`SPSP_ST_RX_AVAIL];
    endproperty
    a_full: assert property (p_full) else $error("receive full flags wrong");

    // Not-empty bit as read back follows the receive count
    property p_rne;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.rvalid) && hit($past(rd_addr), `SPSP_OFF_STATUS)
            |-> st_reg.rdata[`SPSP_ST_RX_AVAIL] == ($past(fifo.rx_count) != 5'd0);
    endproperty
    a_rne: assert property (p_rne) else $error("receive not empty wrong");

    property p_tx;
        @(posedge aclk) disable iff (!aresetn)
        status_w[`SPSP_ST_TX_EMPTY] |-> status_w[`SPSP_ST_TX_ROOM] && raw_w[`SPSP_IRQ_TX];
    endproperty
    a_tx: assert property (p_tx) else $error("transmit flags wrong");

    property p_tnf;
        @(posedge aclk) disable iff (!aresetn)
        (fifo.tx_count == DEPTH_C) |-> !status_w[`SPSP_ST_TX_ROOM];
    endproperty
    a_tnf: assert property (p_tnf) else $error("transmit not full wrong");

    property p_pre_lsb;
        @(posedge aclk) disable iff (!aresetn)
        st_reg.rvalid && hit($past(rd_addr), `SPSP_OFF_PRESCALE) && $rose(st_reg.rvalid)
            |-> !st_reg.rdata[0];
    endproperty
    a_pre_lsb: assert property (p_pre_lsb) else $error("prescale low bit set");

    // Masked word as read back is raw AND enable of the accepting cycle
    property p_mask;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.rvalid) && hit($past(rd_addr), `SPSP_OFF_MASKED)
            |-> st_reg.rdata[3:0] == ($past(raw_w) & $past(st_reg.irq_en));
    endproperty
    a_mask: assert property (p_mask) else $error("masked status wrong");

    property p_ovr;
        @(posedge aclk) disable iff (!aresetn)
        (fifo.rx_push && fifo.rx_count == DEPTH_C) |=> st_reg.ror_raw;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not caught");

    property p_clr;
        @(posedge aclk) disable iff (!aresetn)
        do_write && hit(st_reg.awa, `SPSP_OFF_CLEAR) && st_reg.ws[0] && st_reg.wd[0]
            && !(fifo.rx_push && fifo.rx_count == DEPTH_C) |=> !st_reg.ror_raw;
    endproperty
    a_clr: assert property (p_clr) else $error("overrun not cleared");

    property p_status_hi;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.rvalid) |-> st_reg.rdata[31:8] == 24'h00_0000;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("upper bits set");

    // A receive read holds the time-out flag off
    property p_pop_hold;
        @(posedge aclk) disable iff (!aresetn)
        fifo.rx_pop |=> !$rose(st_reg.rt_raw);
    endproperty
    a_pop_hold: assert property (p_pop_hold) else $error("time-out set despite read");

    // Writing one to the time-out clear bit drops the flag
    property p_rt_clr;
        @(posedge aclk) disable iff (!aresetn)
        do_write && hit(st_reg.awa, `SPSP_OFF_CLEAR) && st_reg.ws[0]
            && st_reg.wd[`SPSP_IRQ_RT] && (fifo.rx_pop || !bit_tick) |=> !st_reg.rt_raw;
    endproperty
    a_rt_clr: assert property (p_rt_clr) else $error("time-out not cleared");

    // Enables come out of reset masked
    property p_en_rst;
        @(posedge aclk)
        $rose(aresetn) |-> st_reg.irq_en == 4'h0 && irq_masked == 4'h0;
    endproperty
    a_en_rst: assert property (p_en_rst) else $error("enables not reset");

    // Stopping the port stops the bit clock
    property p_tick_stop;
        @(posedge aclk) disable iff (!aresetn)
        !port_enable |=> !bit_tick;
    endproperty
    a_tick_stop: assert property (p_tick_stop) else $error("tick while stopped");

    // Main scenarios reached
    c_mask:  cover property (@(posedge aclk) disable iff (!aresetn) irq_masked != 4'h0);
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
    c_ovr:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_reg.ror_raw));
    c_to:    cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_reg.rt_raw));

endmodule // spsp_status

`default_nettype wire

// [design/spsp_consts.svh]
// Register offsets, field positions, reset values and timing counts of the serial port status block
`ifndef SPSP_CONSTS_SVH
`define SPSP_CONSTS_SVH

// Register byte offsets
`define SPSP_OFF_STATUS     12'h000
`define SPSP_OFF_PRESCALE   12'h004
`define SPSP_OFF_IRQ_EN     12'h008
`define SPSP_OFF_RAW        12'h00C
`define SPSP_OFF_MASKED     12'h010
`define SPSP_OFF_CLEAR      12'h014

// Status bit positions
`define SPSP_ST_BUSY        4
`define SPSP_ST_RX_FULL     3
`define SPSP_ST_RX_AVAIL    2
`define SPSP_ST_TX_ROOM     1
`define SPSP_ST_TX_EMPTY    0

// Interrupt bit positions (enable, raw, masked, clear)
`define SPSP_IRQ_TX         3
`define SPSP_IRQ_RX         2
`define SPSP_IRQ_RT         1
`define SPSP_IRQ_ROR        0

// Reset values
`define SPSP_RST_PRESCALE   8'h00
`define SPSP_RST_IRQ_EN     4'h0

// Receive time-out in serial bit periods
`define SPSP_TIMEOUT_BITS   32

// AXI responses
`define SPSP_RESP_OKAY      2'b00
`define SPSP_RESP_SLVERR    2'b10

`endif

// [design/spsp_pkg.sv]
// Types shared by the serial port status block
package spsp_pkg;

    // Fill state reported by the FIFOs outside this block
    typedef struct packed {
        logic [4:0] tx_count;   // Entries in transmit FIFO
        logic [4:0] rx_count;   // Entries in receive FIFO
        logic       rx_push;    // Receive FIFO write strobe
        logic       rx_pop;     // Receive FIFO read strobe
        logic       shifting;   // Frame in progress
    } spsp_fifo_t;

    // AXI4-Lite request side
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } spsp_axi_req_t;

    // AXI4-Lite answer side
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } spsp_axi_rsp_t;

endpackage

// [design/spsp_prescale.sv]
// Bit clock prescaler: one-cycle enable pulse every divisor cycles with the divisor low bit cleared, no pulse below 2
`timescale 1ns/100ps
`default_nettype none

module spsp_prescale
    import spsp_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] divisor,
    // Output
    output logic            bit_tick
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] cnt;    // Cycles since last tick
        logic       tick;   // Registered tick
    } spsp_pre_state_t;

    spsp_pre_state_t st_reg;   // Registered state
    spsp_pre_state_t st_next;  // Next state

    // Divide count; even divisor, low bit ignored
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!run || divisor[7:1] == 7'h00) begin
            // Stopped or illegal divisor clears the count, no tick
            st_next.cnt = 8'h00;
        end else if (st_reg.cnt >= {divisor[7:1], 1'b0} - 8'h01) begin
            st_next.cnt  = 8'h00;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
    end

    // Register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bit_tick = st_reg.tick;

    // Tick spacing equals the divisor
    property p_tick_spacing;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.tick && run && $stable(divisor) && divisor == 8'h04)
            |-> ##1 !st_reg.tick [*3];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too early");

endmodule // spsp_prescale

`default_nettype wire

// [testbench/spsp_fifo_model.sv]
// Stand-in for the data path FIFOs that feed the status block
`timescale 1ns/100ps
`default_nettype none

module spsp_fifo_model
    import spsp_pkg::*;
(
    // Clock
    input  wire logic  aclk,
    // Fill state towards the block
    output var spsp_fifo_t fifo
);
    // Empty FIFOs and no frame at time zero
    initial begin
        fifo = '0;
    end

    // Load new counts and frame state just after an edge
    task automatic set_fill(input logic [4:0] tx, input logic [4:0] rx, input logic sh);
        @(posedge aclk);
        fifo.tx_count <= tx;
        fifo.rx_count <= rx;
        fifo.shifting <= sh;
    endtask

    // One-cycle receive write strobe, the count is left to the caller
    task automatic push_one();
        @(posedge aclk);
        fifo.rx_push <= 1'b1;
        @(posedge aclk);
        fifo.rx_push <= 1'b0;
    endtask

    // Receive read strobe held high for a number of cycles
    task automatic pop_for(input int n);
        @(posedge aclk);
        fifo.rx_pop <= 1'b1;
        repeat (n) @(posedge aclk);
        fifo.rx_pop <= 1'b0;
    endtask
endmodule // spsp_fifo_model

`default_nettype wire

// [testbench/spi_status_prescale_irq_tb.sv]
// Self-checking bench of the serial port status block
`timescale 1ns/100ps
`default_nettype none

`include "spsp_consts.svh"

module spi_status_prescale_irq_tb;
    import spsp_pkg::*;

    // Register addresses
    localparam logic [11:0] st_a  = `SPSP_OFF_STATUS;
    localparam logic [11:0] pre_a = `SPSP_OFF_PRESCALE;
    localparam logic [11:0] en_a  = `SPSP_OFF_IRQ_EN;
    localparam logic [11:0] raw_a = `SPSP_OFF_RAW;
    localparam logic [11:0] mis_a = `SPSP_OFF_MASKED;
    localparam logic [11:0] clr_a = `SPSP_OFF_CLEAR;

    logic          aclk;        // System clock
    logic          aresetn;     // Reset, active low
    spsp_axi_req_t req;         // Bus requests
    spsp_axi_rsp_t rsp;         // Bus answers
    spsp_fifo_t    fifo;        // Fill state from the model
    logic          port_enable; // Runs the prescaler
    logic          bit_tick;    // Bit clock pulse
    logic [3:0]    irq_masked;  // Masked sources
    logic [15:0]   width_mask;  // Entry width mask
    int            failures;    // Mismatches
    int            n_compared;  // Comparisons made

    // Short time-out so the bench stays quick
    spsp_status #(.TIMEOUT_B(2)) u_dut (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .axi_req     (req),
        .axi_rsp     (rsp),
        .fifo        (fifo),
        .port_enable (port_enable),
        .bit_tick    (bit_tick),
        .irq_masked  (irq_masked),
        .width_mask  (width_mask)
    );

    // Data path stand-in
    spsp_fifo_model u_fifo (
        .aclk (aclk),
        .fifo (fifo)
    );

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // ******************************
    // Checking and bus tasks
    // ******************************

    // Compare one value, count it, report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Count a spent wait bound and close the run
    task automatic give_up(input int n);
        if (n > 600) begin
            failures++;
            end_sim();
        end
    endtask

    // Write one word; handshakes are judged on the settled values before each edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t;
        logic w_t;
        logic b_t;
        int   n;
        n = 0;
        b_t = 1'b0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = req.awvalid && rsp.awready;
            w_t  = req.wvalid && rsp.wready;
            b_t  = rsp.bvalid;
            r    = rsp.bresp;
            @(posedge aclk);
            if (aw_t) req.awvalid <= 1'b0;
            if (w_t) req.wvalid <= 1'b0;
            n++;
            give_up(n);
        end
        req.bready <= 1'b0;
    endtask

    // Read one word, holding rready until the answer is seen
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t;
        logic r_t;
        int   n;
        n = 0;
        r_t = 1'b0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = req.arvalid && rsp.arready;
            r_t  = rsp.rvalid;
            d    = rsp.rdata;
            r    = rsp.rresp;
            @(posedge aclk);
            if (ar_t) req.arvalid <= 1'b0;
            n++;
            give_up(n);
        end
        req.rready <= 1'b0;
    endtask

    // Write expecting an OKAY answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(32'(r), 32'(`SPSP_RESP_OKAY));
    endtask

    // Read expecting OKAY and a given low byte, upper bits zero
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, 32'(e));
        chk(32'(r), 32'(`SPSP_RESP_OKAY));
    endtask

    // Gap in cycles between two bit ticks
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        do begin @(negedge aclk); n++; end while (bit_tick !== 1'b1 && n < 601);
        give_up(n);
        n = 0;
        do begin @(negedge aclk); n++; end while (bit_tick !== 1'b1 && n < 601);
        give_up(n);
        chk(32'(n), 32'(e));
    endtask

    // No tick may appear for a while
    task automatic no_ticks();
        int n;
        n = 0;
        repeat (20) begin @(negedge aclk); if (bit_tick === 1'b1) n++; end
        chk(32'(n), 32'h0000_0000);
    endtask

    // Set the fill state, then read status and raw sources
    task automatic fill_chk(input logic [4:0] tx, input logic [4:0] rx, input logic sh,
                            input logic [7:0] st, input logic [7:0] rw);
        u_fifo.set_fill(tx, rx, sh);
        rd_chk(st_a, st);
        rd_chk(raw_a, rw);
    endtask

    // ******************************
    // Scenarios
    // ******************************

    // Reset values, read-only status, unmapped place
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(st_a, 8'h03);
        rd_chk(pre_a, 8'h00);
        rd_chk(en_a, 8'h00);
        rd_chk(raw_a, 8'h08);
        rd_chk(mis_a, 8'h00);
        wr(st_a, 32'hFFFF_FFFF);
        rd_chk(st_a, 8'h03);
        axi_rd(12'h020, d, r);
        chk(32'(r), 32'(`SPSP_RESP_SLVERR));
        chk(32'(width_mask), 32'h0000_FFFF);
    endtask

    // Status and level sources over several fill states
    task automatic t_status();
        fill_chk(5'h00, 5'h00, 1'b1, 8'h13, 8'h08);
        fill_chk(5'h08, 5'h08, 1'b0, 8'h1C, 8'h00);
        fill_chk(5'h00, 5'h01, 1'b0, 8'h07, 8'h0C);
        fill_chk(5'h04, 5'h04, 1'b0, 8'h16, 8'h0C);
        fill_chk(5'h05, 5'h05, 1'b0, 8'h16, 8'h00);
        u_fifo.set_fill(5'h00, 5'h00, 1'b0);
    endtask

    // Divisor values, forced low bit, stop conditions
    task automatic t_prescale();
        no_ticks();
        wr(pre_a, 32'h0000_0005);
        rd_chk(pre_a, 8'h04);
        tick_gap(4);
        wr(pre_a, 32'h0000_00FE);
        rd_chk(pre_a, 8'hFE);
        tick_gap(254);
        wr(pre_a, 32'h0000_0002);
        tick_gap(2);
        @(posedge aclk);
        port_enable <= 1'b0;
        // A tick launched at the stopping edge still shows for one cycle
        @(posedge aclk);
        no_ticks();
        @(posedge aclk);
        port_enable <= 1'b1;
    endtask

    // Time-out, overrun, masking, clearing and restart on reads
    task automatic t_irq();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        d = '0;
        u_fifo.set_fill(5'h00, 5'h01, 1'b0);
        while (d[1] !== 1'b1 && n < 40) begin
            axi_rd(raw_a, d, r);
            n++;
        end
        // Time-out never came: count it and close the run
        if (d[1] !== 1'b1) begin
            give_up(601);
        end
        rd_chk(raw_a, 8'h0E);
        u_fifo.set_fill(5'h00, 5'h08, 1'b0);
        u_fifo.push_one();
        rd_chk(raw_a, 8'h0B);
        u_fifo.set_fill(5'h00, 5'h02, 1'b0);
        rd_chk(mis_a, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(en_a, 32'(1 << i));
            rd_chk(en_a, 8'(1 << i));
            rd_chk(mis_a, 8'(1 << i));
            chk(32'(irq_masked), 32'(1 << i));
        end
        wr(en_a, 32'h0000_0000);
        chk(32'(irq_masked), 32'h0000_0000);
        wr(clr_a, 32'h0000_0000);
        rd_chk(raw_a, 8'h0F);
        u_fifo.set_fill(5'h00, 5'h00, 1'b0);
        wr(clr_a, 32'h0000_0003);
        rd_chk(raw_a, 8'h08);
        rd_chk(clr_a, 8'h00);
        // Data waiting again: time-out returns, reads then hold it off
        u_fifo.set_fill(5'h00, 5'h01, 1'b0);
        repeat (20) @(posedge aclk);
        rd_chk(raw_a, 8'h0E);
        fork
            u_fifo.pop_for(40);
            begin
                wr(clr_a, 32'h0000_0002);
                rd_chk(raw_a, 8'h0C);
            end
        join
        // Reads stopped: the time-out comes back
        repeat (20) @(posedge aclk);
        rd_chk(raw_a, 8'h0E);
        // Overrun raw is low here, so its enable must not show
        wr(en_a, 32'h0000_000F);
        rd_chk(mis_a, 8'h0E);
        chk(32'(irq_masked), 32'h0000_000E);
        wr(en_a, 32'h0000_0000);
    endtask

    // Main sequence: reset for 10 cycles, then each scenario
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        req = '0;
        port_enable = 1'b1;
        failures = 0;
        n_compared = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_status();
        t_prescale();
        t_irq();
        end_sim();
    end
endmodule // spi_status_prescale_irq_tb

`default_nettype wire
